/* verilog/move_load_return_instr_exec.sv */
// Executes literal loads, accumulator stores, configuration load, soft reset and returns.
// Contract
// - Bank load copies literal into bank select.
// - Page load writes latch, flags untouched.
// - Accumulator literal load, flags untouched.
// - Accumulator store to file, one cycle.
// - Indirect store writes through selected pointer.
// - Mode field selects pre/post increment/decrement.
// - Pointer ends plus one, minus one, unchanged.
// - Relative form adds signed offset, pointer kept.
// - Sixteen-bit pointer wraps at both ends.
// - Pointer updates leave status flags alone.
// - Indirect port is no storage; redirects.
// - Configuration load copies accumulator, flags untouched.
// - Soft reset resets device, flags occurrence.
// - Interrupt return pops stack, sets enable.
// - Subroutine return pops stack into counter.
`timescale 1ns/1ps
`default_nettype none
`include "mlr_consts.svh"
module move_load_return_instr_exec #(
    parameter int PC_W = 15
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            clk_en,
    input  wire logic [7:0]      awaddr,
    input  wire logic            awvalid,
    output logic                 awready,
    input  wire logic [31:0]     wdata,
    input  wire logic [3:0]      wstrb,
    input  wire logic            wvalid,
    output logic                 wready,
    output logic [1:0]           bresp,
    output logic                 bvalid,
    input  wire logic            bready,
    input  wire logic [7:0]      araddr,
    input  wire logic            arvalid,
    output logic                 arready,
    output logic [31:0]          rdata,
    output logic [1:0]           rresp,
    output logic                 rvalid,
    input  wire logic            rready,
    input  wire logic            instr_valid,
    input  wire logic [3:0]      instr_op,
    input  wire logic [7:0]      instr_operand,
    input  wire logic            instr_ptr_sel,
    input  wire logic [1:0]      pointer_update_mode,
    input  wire logic            instr_relative,
    input  wire logic [5:0]      instr_offset,
    output logic                 instr_ready,
    input  wire logic [PC_W-1:0] stack_top,
    output logic                 stack_pop,
    output logic [PC_W-1:0]      pc,
    output logic                 rf_we,
    output logic [15:0]          rf_addr,
    output logic [7:0]           rf_wdata,
    output logic [4:0]           bank_select,
    output logic [6:0]           program_counter_high_latch,
    output logic [7:0]           option_cfg,
    output logic [7:0]           irq_control_register,
    output logic [7:0]           power_control_register,
    output logic                 soft_reset_req
);
    exec_pkg::exec_state_e state;
    logic [7:0]  acc;
    logic [15:0] indirect_pointer [0:1];
    logic [15:0] sel_ptr;
    logic [15:0] ind_ea;
    logic [15:0] ind_next;
    logic        fire;
    logic        soft_fire;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_commit;
    logic        wr_hit;
    logic [7:0]  wr_off;
    logic [31:0] rd_data;
    logic        rd_hit;

    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        lane0 = s[0] ? d[7:0] : old;
    endfunction

    function automatic logic [15:0] lane01(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        lane01 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    assign fire      = clk_en && instr_valid && instr_ready;
    assign soft_fire = fire && (instr_op == exec_pkg::OP_SOFT_RESET);
    assign sel_ptr   = indirect_pointer[instr_ptr_sel];
    assign wr_commit = clk_en && aw_full && w_full && !bvalid;
    assign wr_off    = {aw_addr_q[7:2], 2'b00};

    ptr_addr_unit u_ptr (
        .ptr                 (sel_ptr),
        .pointer_update_mode (pointer_update_mode),
        .relative            (instr_relative),
        .offset              (instr_offset),
        .eff_addr            (ind_ea),
        .next_ptr            (ind_next)
    );

    // Sequencing: program counter, return flush and stack pop.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state          <= exec_pkg::ST_EXEC;
            pc             <= `RST_PC;
            instr_ready    <= 1'b1;
            stack_pop      <= 1'b0;
            soft_reset_req <= 1'b0;
        end else if (clk_en) begin
            stack_pop      <= 1'b0;
            soft_reset_req <= 1'b0;
            unique case (state)
                exec_pkg::ST_EXEC: begin
                    if (soft_fire) begin
                        pc             <= `RST_PC;
                        soft_reset_req <= 1'b1;
                    end else if (fire && (instr_op == exec_pkg::OP_RETURN_IRQ ||
                                          instr_op == exec_pkg::OP_RETURN)) begin
                        pc          <= stack_top;
                        stack_pop   <= 1'b1;
                        state       <= exec_pkg::ST_FLUSH;
                        instr_ready <= 1'b0;
                    end else if (fire) begin
                        pc <= pc + PC_W'(1);
                    end
                end
                exec_pkg::ST_FLUSH: begin
                    // Second cycle of a return discards the already fetched word.
                    state       <= exec_pkg::ST_EXEC;
                    instr_ready <= 1'b1;
                end
                default: begin
                    state       <= exec_pkg::ST_EXEC;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end

    // Core data registers; an executing instruction takes priority over a bus write.
    always_ff @(posedge aclk) begin
        if (!aresetn || (soft_fire && state == exec_pkg::ST_EXEC)) begin
            bank_select                <= `RST_BANK;
            program_counter_high_latch <= `RST_PAGE;
            acc                        <= `RST_ACC;
            option_cfg                 <= `RST_OPTION;
            irq_control_register       <= `RST_IRQCTL;
        end else if (clk_en) begin
            if (wr_commit) begin
                unique case (wr_off)
                    `OFF_BANK:   bank_select <= 5'(lane0({3'h0, bank_select}, w_data_q, w_strb_q));
                    `OFF_PAGE:   program_counter_high_latch <= 7'(lane0({1'b0, program_counter_high_latch},
                                                                        w_data_q, w_strb_q));
                    `OFF_ACC:    acc <= lane0(acc, w_data_q, w_strb_q);
                    `OFF_OPTION: option_cfg <= lane0(option_cfg, w_data_q, w_strb_q);
                    `OFF_IRQCTL: irq_control_register <= lane0(irq_control_register, w_data_q, w_strb_q);
                    default: begin
                    end
                endcase
            end
            if (fire) begin
                unique case (instr_op)
                    exec_pkg::OP_LOAD_BANK:   bank_select <= instr_operand[4:0];
                    exec_pkg::OP_LOAD_PAGE:   program_counter_high_latch <= instr_operand[6:0];
                    exec_pkg::OP_LOAD_ACC:    acc <= instr_operand;
                    exec_pkg::OP_LOAD_OPTION: option_cfg <= acc;
                    exec_pkg::OP_RETURN_IRQ:  irq_control_register[`GIE_BIT] <= 1'b1;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Data register file write port.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rf_we    <= 1'b0;
            rf_addr  <= 16'h0000;
            rf_wdata <= 8'h00;
        end else if (clk_en) begin
            rf_we <= 1'b0;
            if (fire && instr_op == exec_pkg::OP_STORE_FILE) begin
                rf_we    <= 1'b1;
                rf_wdata <= acc;
                if (instr_operand[6:0] == `IND_FILE0 || instr_operand[6:0] == `IND_FILE1) begin
                    rf_addr <= indirect_pointer[instr_operand[0]];
                end else begin
                    rf_addr <= {4'h0, bank_select, instr_operand[6:0]};
                end
            end else if (fire && instr_op == exec_pkg::OP_STORE_IND) begin
                rf_we    <= 1'b1;
                rf_wdata <= acc;
                rf_addr  <= ind_ea;
            end
        end
    end

    // Indirect pointers; no status flag is touched by their updates.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
            always_ff @(posedge aclk) begin
                if (!aresetn || (soft_fire && state == exec_pkg::ST_EXEC)) begin
                    indirect_pointer[gi] <= `RST_PTR;
                end else if (clk_en) begin
                    if (fire && instr_op == exec_pkg::OP_STORE_IND && instr_ptr_sel == 1'(gi)) begin
                        indirect_pointer[gi] <= ind_next;
                    end else if (wr_commit && wr_off == (gi == 0 ? `OFF_PTR0 : `OFF_PTR1)) begin
                        indirect_pointer[gi] <= lane01(indirect_pointer[gi], w_data_q, w_strb_q);
                    end
                end
            end
        end
    endgenerate

    // Soft reset flag reads 0 after a soft reset; the event wins over a bus write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_control_register <= `RST_PWRCTL;
        end else if (clk_en) begin
            if (soft_fire) begin
                power_control_register[`SRF_BIT] <= 1'b0;
            end else if (wr_commit && wr_off == `OFF_PWRCTL) begin
                power_control_register <= lane0(power_control_register, w_data_q, w_strb_q);
            end
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        unique case (wr_off)
            `OFF_BANK, `OFF_PAGE, `OFF_ACC, `OFF_OPTION, `OFF_PTR0, `OFF_PTR1, `OFF_IRQCTL, `OFF_PWRCTL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case ({araddr[7:2], 2'b00})
            `OFF_BANK:   rd_data = {27'h0, bank_select};
            `OFF_PAGE:   rd_data = {25'h0, program_counter_high_latch};
            `OFF_ACC:    rd_data = {24'h0, acc};
            `OFF_OPTION: rd_data = {24'h0, option_cfg};
            `OFF_PTR0:   rd_data = {16'h0, indirect_pointer[0]};
            `OFF_PTR1:   rd_data = {16'h0, indirect_pointer[1]};
            `OFF_PC:     rd_data = {{(32 - PC_W){1'b0}}, pc};
            `OFF_IRQCTL: rd_data = {24'h0, irq_control_register};
            `OFF_PWRCTL: rd_data = {24'h0, power_control_register};
            default:     rd_hit = 1'b0;
        endcase
    end

    // Write channel: address and data are held independently, answered together.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_full   <= 1'b0;
            w_full    <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end else if (clk_en) begin
            if (awvalid && awready) begin
                aw_full   <= 1'b1;
                awready   <= 1'b0;
                aw_addr_q <= awaddr;
            end
            if (wvalid && wready) begin
                w_full   <= 1'b1;
                wready   <= 1'b0;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end
            if (wr_commit) begin
                bvalid <= 1'b1;
                bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                aw_full <= 1'b0;
                w_full  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Read channel.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `RESP_OKAY;
        end else if (clk_en) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= rd_data;
                rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_bank;
        fire && instr_op == exec_pkg::OP_LOAD_BANK |=> bank_select == $past(instr_operand[4:0]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select not loaded");

    property p_page;
        fire && instr_op == exec_pkg::OP_LOAD_PAGE |=>
            program_counter_high_latch == $past(instr_operand[6:0]) && $stable(power_control_register);
    endproperty
    a_page: assert property (p_page) else $error("page latch not loaded");

    property p_acc_then_store;
        fire && instr_op == exec_pkg::OP_LOAD_ACC ##1 fire && instr_op == exec_pkg::OP_STORE_FILE
            |=> rf_we && rf_wdata == $past(instr_operand, 2);
    endproperty
    a_acc_then_store: assert property (p_acc_then_store) else $error("stored value differs from literal");

    property p_store_file;
        fire && instr_op == exec_pkg::OP_STORE_FILE && instr_operand[6:1] != 6'h00 |=>
            rf_we && instr_ready && rf_addr == {4'h0, $past(bank_select), $past(instr_operand[6:0])};
    endproperty
    a_store_file: assert property (p_store_file) else $error("file store wrong");

    property p_indirect_port;
        fire && instr_op == exec_pkg::OP_STORE_FILE && instr_operand[6:0] == `IND_FILE1 |=>
            rf_we && rf_addr == $past(indirect_pointer[1]);
    endproperty
    a_indirect_port: assert property (p_indirect_port) else $error("indirect port not redirected");

    property p_pre_inc;
        fire && instr_op == exec_pkg::OP_STORE_IND && !instr_relative &&
            pointer_update_mode == exec_pkg::MODE_PRE_INC |=>
            rf_we && rf_addr == $past(sel_ptr) + 16'h0001 && rf_wdata == $past(acc);
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre-increment address wrong");

    property p_post_dec;
        fire && instr_op == exec_pkg::OP_STORE_IND && !instr_relative && !instr_ptr_sel &&
            pointer_update_mode == exec_pkg::MODE_POST_DEC |=>
            rf_addr == $past(indirect_pointer[0]) && indirect_pointer[0] == $past(indirect_pointer[0]) - 16'h0001;
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong");

    property p_relative;
        fire && instr_op == exec_pkg::OP_STORE_IND && instr_relative && instr_ptr_sel |=>
            rf_addr == $past(indirect_pointer[1]) + {{10{$past(instr_offset[5])}}, $past(instr_offset)} &&
            $stable(indirect_pointer[1]);
    endproperty
    a_relative: assert property (p_relative) else $error("relative store wrong");

    property p_wrap;
        fire && instr_op == exec_pkg::OP_STORE_IND && !instr_relative && !instr_ptr_sel &&
            pointer_update_mode == exec_pkg::MODE_POST_INC && indirect_pointer[0] == 16'hFFFF |=>
            indirect_pointer[0] == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

    property p_option;
        fire && instr_op == exec_pkg::OP_LOAD_OPTION |=> option_cfg == $past(acc);
    endproperty
    a_option: assert property (p_option) else $error("configuration not loaded");

    property p_soft_reset;
        soft_fire |=> soft_reset_req && !power_control_register[`SRF_BIT] && pc == `RST_PC ##1 !soft_reset_req;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong");

    property p_ret_irq;
        fire && instr_op == exec_pkg::OP_RETURN_IRQ |=>
            stack_pop && irq_control_register[`GIE_BIT] && pc == $past(stack_top) && !instr_ready;
    endproperty
    a_ret_irq: assert property (p_ret_irq) else $error("interrupt return wrong");

    property p_return;
        fire && instr_op == exec_pkg::OP_RETURN |=> pc == $past(stack_top) && !instr_ready ##1 instr_ready;
    endproperty
    a_return: assert property (p_return) else $error("return not two cycles");

    property p_nop;
        fire && instr_op == exec_pkg::OP_NOP |=> pc == $past(pc) + PC_W'(1) && !rf_we;
    endproperty
    a_nop: assert property (p_nop) else $error("counter not advanced");

    c_ind: cover property (fire && instr_op == exec_pkg::OP_STORE_IND && instr_relative);
    c_ret: cover property (fire && instr_op == exec_pkg::OP_RETURN_IRQ ##2 instr_ready);
    c_soft: cover property (soft_fire);
    c_axi: cover property (bvalid && bready ##[1:20] rvalid && rready);
endmodule
`default_nettype wire

/* verilog/mlr_consts.svh */
// Offsets, field positions, reset values and cycle counts of the instruction execution block.
`ifndef MLR_CONSTS_SVH
`define MLR_CONSTS_SVH

`define OFF_BANK        8'h00
`define OFF_PAGE        8'h04
`define OFF_ACC         8'h08
`define OFF_OPTION      8'h0C
`define OFF_PTR0        8'h10
`define OFF_PTR1        8'h14
`define OFF_PC          8'h18
`define OFF_IRQCTL      8'h1C
`define OFF_PWRCTL      8'h20

`define GIE_BIT         7
`define SRF_BIT         2

`define RST_BANK        5'h00
`define RST_PAGE        7'h00
`define RST_ACC         8'h00
`define RST_OPTION      8'hFF
`define RST_PTR         16'h0000
`define RST_PC          15'h0000
`define RST_IRQCTL      8'h00
`define RST_PWRCTL      8'h04

`define IND_FILE0       7'h00
`define IND_FILE1       7'h01

`define RET_CYCLES      2

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* verilog/exec_pkg.sv */
// Types shared by the instruction execution block.
package exec_pkg;

    typedef enum logic [3:0] {
        OP_NOP         = 4'h0,
        OP_LOAD_BANK   = 4'h1,
        OP_LOAD_PAGE   = 4'h2,
        OP_LOAD_ACC    = 4'h3,
        OP_STORE_FILE  = 4'h4,
        OP_STORE_IND   = 4'h5,
        OP_LOAD_OPTION = 4'h6,
        OP_SOFT_RESET  = 4'h7,
        OP_RETURN_IRQ  = 4'h8,
        OP_RETURN      = 4'h9
    } op_e;

    typedef enum logic [1:0] {
        MODE_PRE_INC  = 2'h0,
        MODE_PRE_DEC  = 2'h1,
        MODE_POST_INC = 2'h2,
        MODE_POST_DEC = 2'h3
    } ptr_mode_e;

    typedef enum logic [1:0] {
        ST_EXEC  = 2'h1,
        ST_FLUSH = 2'h2
    } exec_state_e;

endpackage

/* verilog/ptr_addr_unit.sv */
// Effective address and pointer update for the indirect store.
`timescale 1ns/1ps
`default_nettype none
module ptr_addr_unit (
    input  wire logic [15:0] ptr,
    input  wire logic [1:0]  pointer_update_mode,
    input  wire logic        relative,
    input  wire logic [5:0]  offset,
    output logic      [15:0] eff_addr,
    output logic      [15:0] next_ptr
);
    logic [15:0] plus_one;
    logic [15:0] minus_one;
    logic [15:0] offset_ext;

    // Plain 16-bit arithmetic wraps at both ends of the pointer range.
    assign plus_one   = ptr + 16'h0001;
    assign minus_one  = ptr - 16'h0001;
    assign offset_ext = {{10{offset[5]}}, offset};

    always_comb begin
        eff_addr = ptr;
        next_ptr = ptr;
        if (relative) begin
            eff_addr = ptr + offset_ext;
        end else begin
            unique case (pointer_update_mode)
                exec_pkg::MODE_PRE_INC: begin
                    eff_addr = plus_one;
                    next_ptr = plus_one;
                end
                exec_pkg::MODE_PRE_DEC: begin
                    eff_addr = minus_one;
                    next_ptr = minus_one;
                end
                exec_pkg::MODE_POST_INC: begin
                    next_ptr = plus_one;
                end
                exec_pkg::MODE_POST_DEC: begin
                    next_ptr = minus_one;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* verif/stack_model.sv */
// Call stack model that offers a return address and pops it on request.
`timescale 1ns/1ps
`default_nettype none
module stack_model #(
    parameter int PC_W = 15
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            stack_pop,
    output logic      [PC_W-1:0] stack_top
);
    logic [2:0] sp;
    assign stack_top = PC_W'(15'h1230 + sp);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp <= 3'h7;
        end else if (stack_pop) begin
            sp <= sp - 3'h1;
        end
    end
endmodule
`default_nettype wire

/* verif/move_load_return_instr_exec_bench.sv */
// Self-checking bench for the instruction execution block.
`timescale 1ns/1ps
`default_nettype none
module move_load_return_instr_exec_bench;
    logic aclk = 0, aresetn = 0, clk_en = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic instr_valid = 0, instr_ptr_sel = 0, instr_relative = 0;
    logic [7:0] awaddr = 0, araddr = 0, instr_operand = 0, acc, k;
    logic [31:0] wdata = 0, seed = 32'hD313AB94, d;
    logic [3:0] wstrb = 4'hF, instr_op = 0;
    logic [1:0] pointer_update_mode = 0, r;
    logic [5:0] instr_offset = 0;
    logic awready, wready, bvalid, arready, rvalid, instr_ready, stack_pop, rf_we, soft_reset_req;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [14:0] stack_top, pc;
    logic [15:0] rf_addr, p, q, e;
    logic [7:0] rf_wdata, option_cfg, irq_control_register, power_control_register;
    logic [4:0] bank_select;
    logic [6:0] program_counter_high_latch;
    logic [23:0] exp_q[$];
    int failures = 0, num_checks = 0, cyc = 0;

    stack_model i_stack (.aclk, .aresetn, .stack_pop, .stack_top);
    move_load_return_instr_exec i_dut (.aclk, .aresetn, .clk_en, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .instr_valid, .instr_op, .instr_operand, .instr_ptr_sel,
        .pointer_update_mode, .instr_relative, .instr_offset, .instr_ready, .stack_top, .stack_pop,
        .pc, .rf_we, .rf_addr, .rf_wdata, .bank_select, .program_counter_high_latch, .option_cfg,
        .irq_control_register, .power_control_register, .soft_reset_req);

    always #10 aclk = ~aclk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end while (!tb);
        bready <= 0;
        check("bresp", r, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge aclk);
            ta = arvalid & arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 0;
        end while (!tr);
        rready <= 0;
        check("rdata", d, ex);
        check("rresp", r, er);
    endtask

    // Issues one instruction; with hold set, valid stays up so the next call follows back to back.
    task automatic ex(input logic [3:0] o, input logic [7:0] kk, input logic [1:0] m = 0,
                      input logic s = 0, input logic rl = 0, input logic [5:0] f = 0, input logic hold = 0);
        if (instr_valid !== 1'b1) @(posedge aclk);
        instr_valid <= 1;
        instr_op <= o;
        instr_operand <= kk;
        pointer_update_mode <= m;
        instr_ptr_sel <= s;
        instr_relative <= rl;
        instr_offset <= f;
        do @(negedge aclk); while (instr_ready !== 1);
        @(posedge aclk);
        if (!hold) begin
            instr_valid <= 0;
            @(negedge aclk);
        end
    endtask

    always @(negedge aclk) begin
        if (rf_we === 1) begin
            check("rf_write", {rf_addr, rf_wdata}, exp_q.pop_front());
        end
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            complete_run;
        end
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(8'h0C, 32'hFF, 2'h0);
        rd(8'h20, 32'h04, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h18, 32'h5, 2'h2);
        check("pc", pc, 15'h0000);
        ex(exec_pkg::OP_NOP, 8'h00);
        check("pc", pc, 15'h0001);
        ex(exec_pkg::OP_LOAD_BANK, 8'h0F);
        check("bank", bank_select, 5'h0F);
        @(posedge aclk);
        clk_en <= 0;
        ex(exec_pkg::OP_LOAD_BANK, 8'h05);
        check("frozen", bank_select, 5'h0F);
        @(posedge aclk);
        clk_en <= 1;
        ex(exec_pkg::OP_LOAD_PAGE, 8'h7F);
        check("page", program_counter_high_latch, 7'h7F);
        seed = lfsr(seed);
        acc = seed[7:0];
        seed = lfsr(seed);
        k = seed[7:0] | 8'h40;
        exp_q.push_back({4'h0, 5'h0F, k[6:0], acc});
        ex(exec_pkg::OP_LOAD_ACC, acc, 0, 0, 0, 0, 1);
        ex(exec_pkg::OP_STORE_FILE, k);
        rd(8'h08, acc, 2'h0);
        ex(exec_pkg::OP_LOAD_OPTION, 8'h00);
        check("option", option_cfg, acc);
        $display("test loads done");
        wr(8'h10, 32'hFFFF, 2'h0);
        p = 16'hFFFF;
        for (int m = 0; m < 4; m++) begin
            q = m[0] ? p - 16'h1 : p + 16'h1;
            e = m[1] ? p : q;
            exp_q.push_back({e, acc});
            ex(exec_pkg::OP_STORE_IND, 8'h00, m[1:0]);
            rd(8'h10, q, 2'h0);
            p = q;
        end
        wr(8'h14, 32'h0010, 2'h0);
        exp_q.push_back({16'hFFF0, acc});
        ex(exec_pkg::OP_STORE_IND, 8'h00, 2'h0, 1'b1, 1'b1, 6'h20);
        rd(8'h14, 32'h0010, 2'h0);
        exp_q.push_back({16'h0010, acc});
        ex(exec_pkg::OP_STORE_FILE, 8'h01);
        $display("test indirect done");
        ex(exec_pkg::OP_RETURN, 8'h00);
        check("pc", pc, 15'h1237);
        check("pop", stack_pop, 1'b1);
        check("ready", instr_ready, 1'b0);
        ex(exec_pkg::OP_RETURN_IRQ, 8'h00);
        check("pc", pc, 15'h1236);
        check("enable", irq_control_register[7], 1'b1);
        ex(exec_pkg::OP_SOFT_RESET, 8'h00);
        check("soft_req", soft_reset_req, 1'b1);
        check("flag", power_control_register[2], 1'b0);
        check("pc", pc, 15'h0000);
        $display("test returns done");
        check("queue", exp_q.size(), 0);
        complete_run;
    end
endmodule
`default_nettype wire
